// File: sxs_pkg.sv
// sxs_pkg: constants, register map and encodings of the sub/xor/swap alu slice
// assumes: nothing beyond a systemverilog compiler
package sxs_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FILE_DEPTH = 128;
   localparam int FADDR_W = 7;
   localparam int PADDR_W = 12;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CMD = 12'h000;
   localparam logic [11:0] OFS_WREG = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [2:0] FILE_WIN_TAG = 3'h1;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_DEST_BIT = 2;
   localparam int CMD_FADDR_LSB = 8;
   localparam int CMD_LIT_LSB = 16;
   localparam int ST_CARRY_BIT = 0;
   localparam int ST_DC_BIT = 1;
   localparam int ST_ZERO_BIT = 2;
   localparam int ST_BUSY_BIT = 8;
   localparam int FILE_IDX_LSB = 2;
   localparam int FILE_TAG_LSB = 9;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] WREG_RST = 8'h00;
   localparam logic FLAG_RST = 1'b0;

   // ----------------------------------------------------------------
   // operations and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SXS_OP_SUBTRACT_W_FROM_FILE = 2'b00,
      SXS_OP_XOR_LITERAL_INTO_W = 2'b01,
      SXS_OP_SWAP_FILE_NIBBLES = 2'b10,
      SXS_OP_XOR_W_WITH_FILE = 2'b11
   } sxs_op_e;

   typedef enum logic [1:0] {
      SXS_ST_IDLE = 2'b00,
      SXS_ST_FETCH = 2'b01,
      SXS_ST_EXEC = 2'b10
   } sxs_state_e;

endpackage

// File: sxs_file_mem.sv
// sxs_file_mem: data register file, one port, registered read data
// assumes: caller never reads and writes the same cycle with conflicting intent
`timescale 1ns/10ps
module sxs_file_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // access port
   input wire logic [AW-1:0] addr_in,
   input wire logic we_in,
   input wire logic [WIDTH-1:0] wdata_in,
   output logic [WIDTH-1:0] rdata_out
);

   initial begin
      if (DEPTH > (1 << AW) || WIDTH < 1) begin
         $error("sxs_file_mem: depth does not fit address width");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
   end

   // read data from a register so timing stays one flop deep
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= mem[addr_in];
      end
   end

endmodule // sxs_file_mem

// File: sxs_alu_slice.sv
// sxs_alu_slice: 8-bit alu slice for four file/literal operations, apb slave
// assumes: apb3 master on clk_in, no pstrb, one outstanding transfer
//
// Operation
// - subtract: file minus working register, twos complement
// - destination bit 0 to w, 1 to file
// - digit carry clear when w low nibble larger
// - literal xor into w, zero flag only
// - swap file nibbles, flags unchanged
// - file xor w, routed by destination, zero only
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module sxs_alu_slice #(
   parameter int FILE_DEPTH = sxs_pkg::FILE_DEPTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // status
   output logic busy_out
);

   initial begin
      if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin
         $error("sxs_alu_slice: file depth must be 1..128");
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sxs_pkg::sxs_state_e state;
   sxs_pkg::sxs_state_e next_state;
   logic [7:0] wreg;
   logic carry;
   logic dcarry;
   logic zero;
   logic [1:0] cmd_op;
   logic cmd_dest;
   logic [6:0] cmd_faddr;
   logic [7:0] cmd_lit;
   logic stage;
   logic [7:0] mem_rdata;
   logic [6:0] mem_addr;
   logic mem_we;
   logic [7:0] mem_wdata;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic access;
   logic commit;
   logic hit_cmd;
   logic hit_wreg;
   logic hit_status;
   logic hit_file;
   logic mapped;

   assign access = psel_in && penable_in;
   // a transfer completes at the edge where pready is seen high
   assign commit = access && pready_out;
   assign hit_cmd = (paddr_in == sxs_pkg::OFS_CMD);
   assign hit_wreg = (paddr_in == sxs_pkg::OFS_WREG);
   assign hit_status = (paddr_in == sxs_pkg::OFS_STATUS);
   assign hit_file = (paddr_in[11:sxs_pkg::FILE_TAG_LSB] == sxs_pkg::FILE_WIN_TAG)
      && (paddr_in[1:0] == 2'h0);
   assign mapped = hit_cmd || hit_wreg || hit_status || hit_file;

   // two cycles per transfer: one to read the file, one to present data;
   // accesses stall while an operation runs so the file port never collides
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         stage <= 1'b0;
      end else begin
         stage <= access && !pready_out && !stage && (state == sxs_pkg::SXS_ST_IDLE);
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else if (stage) begin
         pready_out <= 1'b1;
         pslverr_out <= !mapped;
         prdata_out <= 32'h0000_0000;
         if (!pwrite_in) begin
            if (hit_wreg) begin
               prdata_out <= {24'h00_0000, wreg};
            end else if (hit_status) begin
               prdata_out <= {23'h0, busy_out, 5'h00, zero, dcarry, carry};
            end else if (hit_file) begin
               prdata_out <= {24'h00_0000, mem_rdata};
            end else if (hit_cmd) begin
               prdata_out <= {8'h00, cmd_lit, 1'b0, cmd_faddr, 5'h00, cmd_dest, cmd_op};
            end
         end
      end else begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // command capture and sequencing
   // ----------------------------------------------------------------
   logic start;
   assign start = commit && pwrite_in && hit_cmd;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cmd_op <= sxs_pkg::SXS_OP_SUBTRACT_W_FROM_FILE;
         cmd_dest <= 1'b0;
         cmd_faddr <= 7'h00;
         cmd_lit <= 8'h00;
      end else if (start) begin
         cmd_op <= pwdata_in[sxs_pkg::CMD_OP_LSB +: 2];
         cmd_dest <= pwdata_in[sxs_pkg::CMD_DEST_BIT];
         cmd_faddr <= pwdata_in[sxs_pkg::CMD_FADDR_LSB +: 7];
         cmd_lit <= pwdata_in[sxs_pkg::CMD_LIT_LSB +: 8];
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         sxs_pkg::SXS_ST_IDLE: begin
            if (start) begin
               next_state = sxs_pkg::SXS_ST_FETCH;
            end
         end
         sxs_pkg::SXS_ST_FETCH: begin
            next_state = sxs_pkg::SXS_ST_EXEC;
         end
         sxs_pkg::SXS_ST_EXEC: begin
            next_state = sxs_pkg::SXS_ST_IDLE;
         end
         default: begin
            next_state = sxs_pkg::SXS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state <= sxs_pkg::SXS_ST_IDLE;
         busy_out <= 1'b0;
      end else begin
         state <= next_state;
         busy_out <= (next_state != sxs_pkg::SXS_ST_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   logic exec;
   logic [7:0] result;
   logic [8:0] diff;
   logic to_file;

   assign exec = (state == sxs_pkg::SXS_ST_EXEC);
   // borrow-free when w does not exceed f, so bit 8 clear means carry set
   assign diff = {1'b0, mem_rdata} - {1'b0, wreg};

   always_comb begin
      unique case (cmd_op)
         sxs_pkg::SXS_OP_SUBTRACT_W_FROM_FILE: result = diff[7:0];
         sxs_pkg::SXS_OP_XOR_LITERAL_INTO_W: result = wreg ^ cmd_lit;
         sxs_pkg::SXS_OP_SWAP_FILE_NIBBLES: result = {mem_rdata[3:0], mem_rdata[7:4]};
         sxs_pkg::SXS_OP_XOR_W_WITH_FILE: result = wreg ^ mem_rdata;
      endcase
   end

   // the literal operation always lands in w, whatever the dest bit
   assign to_file = cmd_dest && (cmd_op != sxs_pkg::SXS_OP_XOR_LITERAL_INTO_W);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wreg <= sxs_pkg::WREG_RST;
      end else if (exec && !to_file) begin
         wreg <= result;
      end else if (commit && pwrite_in && hit_wreg) begin
         wreg <= pwdata_in[7:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         carry <= sxs_pkg::FLAG_RST;
         dcarry <= sxs_pkg::FLAG_RST;
         zero <= sxs_pkg::FLAG_RST;
      end else if (exec) begin
         if (cmd_op == sxs_pkg::SXS_OP_SUBTRACT_W_FROM_FILE) begin
            carry <= !diff[8];
            dcarry <= (wreg[3:0] <= mem_rdata[3:0]);
         end
         if (cmd_op != sxs_pkg::SXS_OP_SWAP_FILE_NIBBLES) begin
            zero <= (result == 8'h00);
         end
      end else if (commit && pwrite_in && hit_status) begin
         carry <= pwdata_in[sxs_pkg::ST_CARRY_BIT];
         dcarry <= pwdata_in[sxs_pkg::ST_DC_BIT];
         zero <= pwdata_in[sxs_pkg::ST_ZERO_BIT];
      end
   end

   // ----------------------------------------------------------------
   // file register port
   // ----------------------------------------------------------------
   always_comb begin
      mem_addr = paddr_in[sxs_pkg::FILE_IDX_LSB +: 7];
      mem_we = commit && pwrite_in && hit_file;
      mem_wdata = pwdata_in[7:0];
      if (state != sxs_pkg::SXS_ST_IDLE) begin
         mem_addr = cmd_faddr;
         mem_we = exec && to_file;
         mem_wdata = result;
      end
   end

   sxs_file_mem #(
      .WIDTH(sxs_pkg::DATA_W),
      .DEPTH(FILE_DEPTH),
      .AW(sxs_pkg::FADDR_W)
   ) u_file (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .addr_in(mem_addr),
      .we_in(mem_we),
      .wdata_in(mem_wdata),
      .rdata_out(mem_rdata)
   );

endmodule // sxs_alu_slice

// File: sxs_alu_slice_checker.sv
// apb timing and op-run properties of the alu slice
// assumes: bound to sxs_alu_slice, sees its ports only
`timescale 1ns/10ps
module sxs_alu_slice_checker (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // apb and status
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic busy_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire logic acc = psel_in && penable_in;
   wire logic cmd = acc && pready_out && pwrite_in && paddr_in == sxs_pkg::OFS_CMD;
   // ----
   // properties
   // ----
   sequence s_run;
      busy_out [*2] ##1 !busy_out;
   endsequence
   property p_run;
      cmd |=> s_run;
   endproperty
   a_run: assert property (p_run) else $error("op run length wrong");
   property p_cause;
      $rose(busy_out) |-> $past(cmd);
   endproperty
   a_cause: assert property (p_cause) else $error("op without command");
   property p_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held");
   property p_acc;
      pready_out |-> acc;
   endproperty
   a_acc: assert property (p_acc) else $error("ready without access");
   property p_stall;
      busy_out |-> !pready_out;
   endproperty
   a_stall: assert property (p_stall) else $error("answer while busy");
   // idle slave: one read stage, then the answer
   sequence s_answer;
      !pready_out ##1 !pready_out ##1 pready_out;
   endsequence
   property p_lat;
      $rose(penable_in) && psel_in && !busy_out |-> s_answer;
   endproperty
   a_lat: assert property (p_lat) else $error("answer latency wrong");
   property p_err;
      pready_out && paddr_in == 12'h00C |-> pslverr_out && prdata_out == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_wdat;
      pready_out && paddr_in == sxs_pkg::OFS_WREG |-> !pslverr_out && prdata_out[31:8] == 24'h0;
   endproperty
   a_wdat: assert property (p_wdat) else $error("working reg read bad");
endmodule // sxs_alu_slice_checker

bind sxs_alu_slice sxs_alu_slice_checker sxs_alu_slice_checker_i (.clk_in, .sys_rst_in,
   .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
   .pslverr_out, .busy_out);

// File: sxs_apb_master.sv
// apb master standing in for the decoder side
// assumes: one transfer at a time, called from the bench
`timescale 1ns/10ps
module sxs_apb_master (
   // clock
   input wire logic clk_in,
   // apb request
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [11:0] paddr_out,
   output logic [31:0] pwdata_out,
   // apb answer
   input wire logic [31:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in
);
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 12'h000;
      pwdata_out = 32'h0;
   end
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge clk_in);
      psel_out <= 1'b1;
      pwrite_out <= wr;
      paddr_out <= a;
      pwdata_out <= wd;
      @(posedge clk_in);
      penable_out <= 1'b1;
      do @(posedge clk_in); while (pready_in !== 1'b1);
      rd = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // released data flips so stale values never look valid
      pwdata_out <= ~wd;
   endtask
endmodule // sxs_apb_master

// File: sxs_alu_slice_bench.sv
// self-checking bench of the alu slice
// assumes: apb master model drives every apb input of the slave
`timescale 1ns/10ps
module sxs_alu_slice_bench;
   localparam logic [11:0] AW = sxs_pkg::OFS_WREG;
   localparam logic [11:0] AS = sxs_pkg::OFS_STATUS;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, busy_out, err;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #2 clk_in = ~clk_in;
   sxs_alu_slice sxs_alu_slice_i (.clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .busy_out);
   sxs_apb_master sxs_apb_master_i (.clk_in, .psel_out(psel_in), .penable_out(penable_in),
      .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in),
      .prdata_in(prdata_out), .pready_in(pready_out), .pslverr_in(pslverr_out));
   // ----
   // helpers
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      sxs_apb_master_i.xfer(1'b1, a, d, rd, err);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      sxs_apb_master_i.xfer(1'b0, a, 32'h0, rd, err);
      chk(rd, e);
   endtask
   function automatic logic [11:0] fa(input logic [6:0] f);
      fa = {3'h1, f, 2'b00};
   endfunction
   task automatic op(input logic [1:0] o, input logic d, input logic [6:0] f,
      input logic [7:0] k);
      wr(sxs_pkg::OFS_CMD, {8'h00, k, 1'b0, f, 5'h00, d, o});
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_sub;
      logic [7:0] f [4] = '{8'h3A, 8'h2C, 8'h10, 8'h08};
      logic [7:0] w [4] = '{8'h2C, 8'h2C, 8'h80, 8'h01};
      logic [7:0] r;
      for (int i = 0; i < 4; i++) begin
         r = f[i] - w[i];
         wr(fa(7'd5), {24'h0, f[i]});
         wr(AW, {24'h0, w[i]});
         op(sxs_pkg::SXS_OP_SUBTRACT_W_FROM_FILE, 1'b0, 7'd5, 8'h00);
         rdc(AW, {24'h0, r});
         rdc(AS, {29'h0, r == 8'h00, w[i][3:0] <= f[i][3:0], w[i] <= f[i]});
         rdc(fa(7'd5), {24'h0, f[i]});
      end
      wr(fa(7'd127), 32'h3A);
      op(sxs_pkg::SXS_OP_SUBTRACT_W_FROM_FILE, 1'b1, 7'd127, 8'h00);
      rdc(fa(7'd127), 32'h33);
      rdc(AW, 32'h07);
      rdc(AS, 32'h3);
   endtask
   task automatic t_xor;
      wr(AS, 32'h3);
      wr(AW, 32'h5A);
      op(sxs_pkg::SXS_OP_XOR_LITERAL_INTO_W, 1'b1, 7'd0, 8'h5A);
      rdc(AW, 32'h0);
      rdc(AS, 32'h7);
      wr(fa(7'd3), 32'h0F);
      wr(AW, 32'hF0);
      op(sxs_pkg::SXS_OP_XOR_W_WITH_FILE, 1'b1, 7'd3, 8'h00);
      rdc(fa(7'd3), 32'hFF);
      rdc(AS, 32'h3);
      wr(fa(7'd3), 32'hF0);
      op(sxs_pkg::SXS_OP_XOR_W_WITH_FILE, 1'b0, 7'd3, 8'h00);
      rdc(AW, 32'h0);
      rdc(AS, 32'h7);
   endtask
   task automatic t_swap;
      wr(fa(7'd9), 32'hA5);
      wr(AS, 32'h5);
      op(sxs_pkg::SXS_OP_SWAP_FILE_NIBBLES, 1'b0, 7'd9, 8'h00);
      @(posedge clk_in);
      chk({31'h0, busy_out}, 32'h1);
      repeat (2) @(posedge clk_in);
      chk({31'h0, busy_out}, 32'h0);
      rdc(AW, 32'h5A);
      rdc(AS, 32'h5);
      op(sxs_pkg::SXS_OP_SWAP_FILE_NIBBLES, 1'b1, 7'd9, 8'h00);
      rdc(fa(7'd9), 32'h5A);
      rdc(sxs_pkg::OFS_CMD, 32'h906);
   endtask
   // unmapped write must not land; reset while idle clears w and flags, not the file
   task automatic t_rst;
      wr(AW, 32'h3C);
      wr(AS, 32'h7);
      wr(12'h00C, 32'hFF);
      chk({31'h0, err}, 32'h1);
      rdc(AW, 32'h3C);
      chk({31'h0, err}, 32'h0);
      rdc(AS, 32'h7);
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rdc(AW, 32'h0);
      rdc(AS, 32'h0);
      rdc(fa(7'd9), 32'h5A);
   endtask
   task automatic results;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         results;
      end
   end
   initial begin
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rdc(AW, 32'h0);
      rdc(AS, 32'h0);
      rdc(12'h00C, 32'h0);
      chk({31'h0, err}, 32'h1);
      t_sub;
      t_xor;
      t_swap;
      t_rst;
      results;
   end
endmodule // sxs_alu_slice_bench
